/* hw/hbp_port.sv */
/*
 * Host processor port of a bus interface adapter: register select, data
 * direction, enable-clock timing, switch readback, latched reset and the
 * device-address compare that steps listener and talker addressing.
 * Assumes host pins are asynchronous to MCLK; command and received-byte
 * inputs come from logic on MCLK.
 */
`timescale 1ns/1ps
`include "hbp_params.svh"

module hbp_port (
	input  wire logic       MCLK,
	input  wire logic       RSTN,
	input  wire logic       E,
	input  wire logic       CS_N,
	input  wire logic       RW,
	input  wire logic       REG_SELECT_BIT0,
	input  wire logic       REG_SELECT_BIT1,
	input  wire logic       REG_SELECT_BIT2,
	input  wire logic [7:0] D_IN,
	output logic      [7:0] D_OUT,
	output logic            D_OE,
	output logic            SWITCH_READ_STROBE_N,
	input  wire logic       CMD_VALID,
	input  wire logic [7:0] CMD_BYTE,
	input  wire logic       RX_VALID,
	input  wire logic [7:0] RX_DATA,
	output logic            DAC_HOLD,
	output logic            LISTENER_ADDRESSED,
	output logic            TALKER_ADDRESSED,
	output logic            LATCHED_RESET
);
	logic [1:0]          rst_ff;
	logic                rst_n;
	logic [13:0]         pins_s;
	logic                e_s;
	logic                cs_n_s;
	logic                rw_s;
	logic [2:0]          sel_s;
	logic [7:0]          d_s;
	logic                e_rise;
	logic                e_fall;
	logic                rd;
	logic                wr;
	logic                in_reset;
	hbp_pkg::hbp_state_t st;
	hbp_pkg::hbp_state_t next_st;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic hit(input logic [2:0] sel, input logic [2:0] code);
		hit = (sel == code);
	endfunction

	function automatic logic [7:0] bus_addr(input logic [2:0] grp, input logic [4:0] a);
		bus_addr = {grp, a};
	endfunction

	// --------------------------------------------------------------
	// Reset release through two flip-flops
	// --------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_ff <= 2'h0;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_ff[1];

	// Host pins pass two flip-flops
	hbp_sync u_sync (
		.clk   (MCLK),
		.rst_n (rst_n),
		.d     ({E, CS_N, RW, REG_SELECT_BIT2, REG_SELECT_BIT1, REG_SELECT_BIT0, D_IN}),
		.q     (pins_s)
	);

	// --------------------------------------------------------------
	// Access decode
	// --------------------------------------------------------------
	assign e_s      = pins_s[13];
	assign cs_n_s   = pins_s[12];
	assign rw_s     = pins_s[11];
	assign sel_s    = pins_s[10:8];
	assign d_s      = pins_s[7:0];
	assign e_rise   = e_s & ~st.e_q;
	assign e_fall   = ~e_s & st.e_q;
	assign rd       = ~cs_n_s & rw_s;
	assign wr       = ~cs_n_s & ~rw_s;
	assign in_reset = st.aux[`HBP_AUX_RESET_BIT];

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.e_q  = e_s;
		// Read side: drive only while enable high, never for switch location
		next_st.d_oe = 1'b0;
		next_st.sw_n = ~(e_s & rd & hit(sel_s, `HBP_SEL_ADDRESS));
		next_st.d_out = `HBP_BYTE_ZERO;
		if (e_s && rd && !hit(sel_s, `HBP_SEL_ADDRESS)) begin
			next_st.d_oe = 1'b1;
			if (hit(sel_s, `HBP_SEL_RX_BYTE) && !in_reset) begin
				next_st.d_out = st.rx;
			end else if (hit(sel_s, `HBP_SEL_ADDR_STATUS) && !in_reset) begin
				next_st.d_out[`HBP_STAT_MA_BIT]     = st.talk | st.listen;
				next_st.d_out[`HBP_STAT_TALK_BIT]   = st.talk;
				next_st.d_out[`HBP_STAT_LISTEN_BIT] = st.listen;
			end
		end
		// Write side captured on the falling enable edge
		if (e_fall && wr) begin
			if (hit(sel_s, `HBP_SEL_ADDRESS)) begin
				next_st.addr = d_s;
			end else if (hit(sel_s, `HBP_SEL_AUX_CMD)) begin
				if (in_reset) begin
					next_st.aux[`HBP_AUX_RESET_BIT] = d_s[`HBP_AUX_RESET_BIT];
				end else begin
					next_st.aux = d_s;
				end
			end
		end
		// Reading the received byte releases the held handshake
		if (e_fall && rd && hit(sel_s, `HBP_SEL_RX_BYTE) && !in_reset &&
		    st.lst == hbp_pkg::HBP_L_HOLD) begin
			next_st.lst = hbp_pkg::HBP_L_ADDR;
		end
		// Addressing and byte capture step on enable rising edges
		if (e_rise && !in_reset) begin
			if (CMD_VALID) begin
				if (CMD_BYTE == bus_addr(`HBP_LISTEN_GROUP, st.addr[4:0]) &&
				    !st.addr[`HBP_ADDR_NO_LISTEN]) begin
					if (st.lst == hbp_pkg::HBP_L_IDLE) begin
						next_st.lst = hbp_pkg::HBP_L_ADDR;
					end
				end else if (CMD_BYTE == `HBP_UNLISTEN) begin
					next_st.lst = hbp_pkg::HBP_L_IDLE;
				end
				if (CMD_BYTE == bus_addr(`HBP_TALK_GROUP, st.addr[4:0]) &&
				    !st.addr[`HBP_ADDR_NO_TALK]) begin
					next_st.talk = 1'b1;
				end else if (CMD_BYTE[7:5] == `HBP_TALK_GROUP) begin
					next_st.talk = 1'b0;                                  // Untalk or other talker
				end
			end else if (RX_VALID && st.lst == hbp_pkg::HBP_L_ADDR) begin
				next_st.rx  = RX_DATA;
				next_st.lst = hbp_pkg::HBP_L_HOLD;
			end
		end
		// Latched reset keeps every function idle
		if (in_reset) begin
			next_st.lst  = hbp_pkg::HBP_L_IDLE;
			next_st.talk = 1'b0;
		end
		next_st.listen   = (next_st.lst != hbp_pkg::HBP_L_IDLE);
		next_st.dac_hold = (next_st.lst == hbp_pkg::HBP_L_HOLD);
	end

	// --------------------------------------------------------------
	// State register; hardware reset idles all functions
	// --------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			st          <= '0;
			st.aux      <= `HBP_AUX_RESET_VAL;
			st.addr     <= `HBP_ADDR_RESET_VAL;
			st.sw_n     <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops
	assign D_OUT                = st.d_out;
	assign D_OE                 = st.d_oe;
	assign SWITCH_READ_STROBE_N = st.sw_n;
	assign DAC_HOLD             = st.dac_hold;
	assign LISTENER_ADDRESSED   = st.listen;
	assign TALKER_ADDRESSED     = st.talk;
	assign LATCHED_RESET        = st.aux[`HBP_AUX_RESET_BIT];

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence s_rx_held;
		st.lst == hbp_pkg::HBP_L_HOLD;
	endsequence

	sequence s_rx_read;
		e_fall && rd && hit(sel_s, `HBP_SEL_RX_BYTE);
	endsequence

	a_drive_only_read: assert property (@(posedge MCLK) disable iff (!rst_n)
		D_OE |-> $past(e_s) && $past(rd) && $past(sel_s) != `HBP_SEL_ADDRESS)
		else $error("data driven outside a register read");

	a_strobe_on_switch: assert property (@(posedge MCLK) disable iff (!rst_n)
		(e_s && rd && hit(sel_s, `HBP_SEL_ADDRESS)) |=> !SWITCH_READ_STROBE_N && !D_OE)
		else $error("switch strobe missing on location 4 read");

	a_strobe_only_e: assert property (@(posedge MCLK) disable iff (!rst_n)
		!SWITCH_READ_STROBE_N |-> $past(e_s))
		else $error("switch strobe low outside enable high");

	a_addr_capture: assert property (@(posedge MCLK) disable iff (!rst_n)
		(e_fall && wr && hit(sel_s, `HBP_SEL_ADDRESS)) |=> st.addr == $past(d_s))
		else $error("address write not captured");

	a_reset_aux_low: assert property (@(posedge MCLK) disable iff (!rst_n)
		(e_fall && wr && in_reset && hit(sel_s, `HBP_SEL_AUX_CMD)) |=>
		st.aux[`HBP_AUX_RESET_BIT-1:0] == $past(st.aux[`HBP_AUX_RESET_BIT-1:0]))
		else $error("aux bits written during latched reset");

	a_reset_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
		LATCHED_RESET |=> !TALKER_ADDRESSED && !LISTENER_ADDRESSED && !DAC_HOLD)
		else $error("function active under latched reset");

	a_dac_release: assert property (@(posedge MCLK) disable iff (!rst_n)
		(s_rx_held ##0 s_rx_read ##0 !in_reset) |=> !DAC_HOLD ##1 !DAC_HOLD)
		else $error("handshake not released by byte read");

	a_steps_on_e: assert property (@(posedge MCLK) disable iff (!rst_n)
		(!e_rise && !in_reset && !$fell(in_reset)) |=> $stable(TALKER_ADDRESSED))
		else $error("talker state moved without enable edge");

	a_no_listen_bit6: assert property (@(posedge MCLK) disable iff (!rst_n)
		(!LISTENER_ADDRESSED && st.addr[`HBP_ADDR_NO_LISTEN]) |=> !LISTENER_ADDRESSED)
		else $error("listener addressed with listen disabled");

	a_no_talk_bit5: assert property (@(posedge MCLK) disable iff (!rst_n)
		(!TALKER_ADDRESSED && st.addr[`HBP_ADDR_NO_TALK]) |=> !TALKER_ADDRESSED)
		else $error("talker addressed with talk disabled");

endmodule // hbp_port

/* pkg/hbp_params.svh */
/*
 * Constants of the host bus port: register select codes, field positions,
 * reset values and bus command codes.
 * Assumes it is included by bare name from package and design files.
 */
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define HBP_SEL_ADDR_STATUS 3'h2
`define HBP_SEL_AUX_CMD     3'h3
`define HBP_SEL_ADDRESS     3'h4
`define HBP_SEL_RX_BYTE     3'h7

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define HBP_AUX_RESET_BIT   7
`define HBP_ADDR_NO_LISTEN  6
`define HBP_ADDR_NO_TALK    5
`define HBP_STAT_MA_BIT     7
`define HBP_STAT_TALK_BIT   3
`define HBP_STAT_LISTEN_BIT 2
`define HBP_AUX_RESET_VAL   8'h80
`define HBP_ADDR_RESET_VAL  8'h00
`define HBP_BYTE_ZERO       8'h00

// ----------------------------------------------------------------------
// Multiline command codes seen with the command strobe
// ----------------------------------------------------------------------
`define HBP_LISTEN_GROUP    3'h1
`define HBP_TALK_GROUP      3'h2
`define HBP_UNLISTEN        8'h3f
`define HBP_UNTALK          8'h5f
`define HBP_ALL_ONES_ADDR   5'h1f

`endif

/* pkg/hbp_pkg.sv */
/*
 * Types of the host bus port.
 * Assumes hbp_params.svh is on the include path.
 */
package hbp_pkg;

	// ------------------------------------------------------------------
	// Listener handshake states, Gray coded along idle, addressed, holding
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		HBP_L_IDLE = 2'h0,
		HBP_L_ADDR = 2'h1,
		HBP_L_HOLD = 2'h3
	} hbp_lstate_t;

	// ------------------------------------------------------------------
	// Whole state of the port
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        e_q;
		logic [7:0]  addr;
		logic [7:0]  aux;
		logic [7:0]  rx;
		hbp_lstate_t lst;
		logic        talk;
		logic        listen;
		logic        dac_hold;
		logic [7:0]  d_out;
		logic        d_oe;
		logic        sw_n;
	} hbp_state_t;

endpackage

/* hw/hbp_sync.sv */
/*
 * Two flip-flop synchroniser for the host pins.
 * Assumes an active-low asynchronous reset from the port's reset copy.
 */
`timescale 1ns/1ps

module hbp_sync (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [13:0] d,
	output logic      [13:0] q
);
	logic [13:0] meta;

	// --------------------------------------------------------------
	// First stage feeds only the second
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 14'h0000;
			q    <= 14'h0000;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // hbp_sync

/* verif/hbp_host_model.sv */
/*
 * Host processor model for the host bus port: enable pulses, register
 * accesses and the bus level seen on the shared data lines.
 * Assumes the bench calls its tasks and provides the back-panel switches.
 */
`timescale 1ns/1ps

module hbp_host_model (
	input  wire logic       MCLK,
	input  wire logic [7:0] D_OUT,
	input  wire logic       D_OE,
	input  wire logic       SWITCH_READ_STROBE_N,
	input  wire logic [7:0] sw,
	output logic            e,
	output logic            cs_n,
	output logic            rw,
	output logic      [2:0] sel,
	output logic      [7:0] d_in
);
	logic       drv;
	logic [7:0] wdat;
	logic [7:0] idle = 8'h5a;

	// Idle host pins
	initial begin
		e = 1'b0;
		cs_n = 1'b1;
		rw = 1'b1;
		sel = 3'h0;
		drv = 1'b0;
		wdat = 8'h00;
	end

	// Released bus shows a pattern that changes every cycle
	always @(posedge MCLK) begin
		idle <= ~idle + 8'h01;
	end

	// Bus level: host write, strobed switch buffers, device data or floating
	assign d_in = drv ? wdat : (!SWITCH_READ_STROBE_N ? sw : (D_OE ? D_OUT : idle));

	// One access per enable pulse, held four cycles past the falling edge
	task automatic access(input logic r, input logic [2:0] s, input logic [7:0] w,
			output logic [7:0] rd, output logic st, output logic oe);
		@(posedge MCLK);
		e <= 1'b1;
		cs_n <= 1'b0;
		rw <= r;
		sel <= s;
		wdat <= w;
		drv <= !r;
		repeat (5) @(posedge MCLK);
		@(negedge MCLK);
		rd = d_in;
		st = SWITCH_READ_STROBE_N;
		oe = D_OE;
		@(posedge MCLK);
		e <= 1'b0;
		repeat (4) @(posedge MCLK);
		cs_n <= 1'b1;
		drv <= 1'b0;
		rw <= 1'b1;
	endtask

	// Single enable pulse with no access
	task automatic pulse();
		@(posedge MCLK);
		e <= 1'b1;
		repeat (4) @(posedge MCLK);
		e <= 1'b0;
		repeat (4) @(posedge MCLK);
	endtask
endmodule // hbp_host_model

/* verif/host_bus_port_and_init_bench.sv */
/*
 * Self-checking bench of the host bus port against a behavioural model.
 * Assumes the host model drives the host pins and the bench the link side.
 */
`timescale 1ns/1ps

module host_bus_port_and_init_bench;
	logic MCLK = 1'b0;
	logic RSTN = 1'b0;
	logic CMD_VALID = 1'b0;
	logic RX_VALID = 1'b0;
	logic [7:0] CMD_BYTE = 8'h00;
	logic [7:0] RX_DATA = 8'h00;
	logic [7:0] sw = 8'h00;
	logic e, cs_n, rw, oe, strobe_n, dac, lis, tlk, lrst;
	logic [2:0] sel;
	logic [7:0] d_in, d_out, m_a, m_rx, d1;
	logic m_rst, m_hold, m_t, m_l;
	logic [4:0] a;
	int miscompares = 0;
	int checked = 0;

	// ------------------------------------------------------------------
	// Clock, design and host
	// ------------------------------------------------------------------
	initial begin
		forever #10 MCLK = ~MCLK;
	end

	hbp_port uut (.MCLK(MCLK), .RSTN(RSTN), .E(e), .CS_N(cs_n), .RW(rw), .REG_SELECT_BIT0(sel[0]),
		.REG_SELECT_BIT1(sel[1]), .REG_SELECT_BIT2(sel[2]), .D_IN(d_in), .D_OUT(d_out), .D_OE(oe),
		.SWITCH_READ_STROBE_N(strobe_n), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA), .DAC_HOLD(dac), .LISTENER_ADDRESSED(lis), .TALKER_ADDRESSED(tlk),
		.LATCHED_RESET(lrst));

	hbp_host_model host (.MCLK(MCLK), .D_OUT(d_out), .D_OE(oe), .SWITCH_READ_STROBE_N(strobe_n), .sw(sw),
		.e(e), .cs_n(cs_n), .rw(rw), .sel(sel), .d_in(d_in));

	// ------------------------------------------------------------------
	// Checking and model
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [7:0] exp_rd(input logic [2:0] s);
		case (s)
			3'h2: exp_rd = m_rst ? 8'h00 : {m_t | m_l, 3'h0, m_t, m_l, 2'h0};
			3'h4: exp_rd = sw;
			3'h7: exp_rd = m_rst ? 8'h00 : m_rx;
			default: exp_rd = 8'h00;
		endcase
	endfunction

	// Settled status outputs against the model
	task automatic outs();
		@(negedge MCLK);
		chk({4'h0, lrst, dac, tlk, lis}, {4'h0, m_rst, m_hold, m_t, m_l});
	endtask

	task automatic do_reset();
		@(posedge MCLK);
		RSTN <= 1'b0;
		repeat (4) @(posedge MCLK);
		RSTN <= 1'b1;
		repeat (3) @(posedge MCLK);
		{m_a, m_rx, m_rst, m_hold, m_t, m_l} = {16'h0, 4'h8};
		outs();
	endtask

	task automatic acc(input logic r, input logic [2:0] s, input logic [7:0] w);
		logic [7:0] rd;
		logic st;
		logic o;
		host.access(r, s, w, rd, st, o);
		if (r) begin
			chk(rd, exp_rd(s));
			chk({7'h0, o}, {7'h0, s != 3'h4});
			chk({7'h0, st}, {7'h0, s != 3'h4});
			m_hold = (s == 3'h7) ? 1'b0 : m_hold;
		end else if (s == 3'h4) begin
			m_a = w;
		end else if (s == 3'h3) begin
			m_rst = w[7];
			{m_hold, m_t, m_l} = m_rst ? 3'h0 : {m_hold, m_t, m_l};
		end
		outs();
		chk({6'h0, strobe_n, oe}, 8'h02);
		chk(d_out, 8'h00);
	endtask

	task automatic cmd(input logic [7:0] b, input int stall);
		@(posedge MCLK);
		CMD_VALID <= 1'b1;
		CMD_BYTE <= b;
		repeat (stall) @(posedge MCLK);
		outs();
		host.pulse();
		CMD_VALID <= 1'b0;
		if (!m_rst && b[7:5] == 3'h1)
			m_l = (b == 8'h3f) ? 1'b0 : ((b[4:0] == m_a[4:0] && !m_a[6]) ? 1'b1 : m_l);
		// Leaving the listener state drops any held byte
		m_hold = m_hold & m_l;
		if (!m_rst && b[7:5] == 3'h2)
			m_t = (b == 8'h5f || b[4:0] != m_a[4:0] || m_a[5]) ? 1'b0 : 1'b1;
		outs();
	endtask

	task automatic rx(input logic [7:0] b);
		@(posedge MCLK);
		RX_VALID <= 1'b1;
		RX_DATA <= b;
		host.pulse();
		RX_VALID <= 1'b0;
		if (!m_rst && m_l && !m_hold)
			{m_rx, m_hold} = {b, 1'b1};
		outs();
	endtask

	// ------------------------------------------------------------------
	// Watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (30000) @(posedge MCLK);
		miscompares++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h4c0b9f45));
		a = 5'($urandom_range(29));
		d1 = 8'($urandom);
		sw = {3'h0, a};
		do_reset();
		for (int s = 0; s < 8; s++) acc(1'b1, 3'(s), 8'h00);
		cmd(8'h20, 0);
		acc(1'b1, 3'h4, 8'h00);
		acc(1'b0, 3'h4, sw);
		acc(1'b0, 3'h3, 8'h7f);
		for (int s = 0; s < 7; s++) acc(1'b1, 3'(s), 8'h00);
		cmd(8'h20 | {3'h0, a ^ 5'h01}, 0);
		cmd(8'h20 | {3'h0, a}, 40);
		rx(d1);
		rx(~d1);
		acc(1'b1, 3'h2, 8'h00);
		acc(1'b1, 3'h7, 8'h00);
		cmd(8'h3f, 0);
		rx(8'($urandom));
		cmd(8'h40 | {3'h0, a}, 0);
		acc(1'b1, 3'h2, 8'h00);
		cmd(8'h40 | {3'h0, a ^ 5'h01}, 0);
		cmd(8'h40 | {3'h0, a}, 0);
		cmd(8'h5f, 0);
		acc(1'b0, 3'h4, 8'h60 | {3'h0, a});
		cmd(8'h20 | {3'h0, a}, 0);
		cmd(8'h40 | {3'h0, a}, 0);
		do_reset();
		acc(1'b0, 3'h3, 8'h00);
		cmd(8'h20, 0);
		rx(d1);
		cmd(8'h3f, 0);
		end_of_test();
	end
endmodule // host_bus_port_and_init_bench
